// ### rtl/irq_status_mask.sv
`timescale 1ns/1ps
module irq_status_mask
    import irq_stat_pkg::*;
(
    input  wire logic                   sys_clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   cen_i,
    // register port
    input  wire logic [31:0]            reg_addr_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    input  wire logic [REG_WIDTH-1:0]   reg_wdata_i,
    output logic [REG_WIDTH-1:0]        reg_rdata_o,
    // controller state
    input  wire logic                   enable_bit_i,
    input  wire logic                   internal_enable_signal_i,
    input  wire logic                   fsm_active_i,
    input  wire logic [LEVEL_WIDTH-1:0] tx_level_i,
    input  wire logic [LEVEL_WIDTH-1:0] rx_level_i,
    input  wire logic [LEVEL_WIDTH-1:0] tx_threshold_setting_i,
    input  wire logic [LEVEL_WIDTH-1:0] rx_threshold_setting_i,
    // events from the controller core
    input  wire logic                   data_command_port_wr_i,
    input  wire logic                   data_command_port_rd_i,
    input  wire logic                   rx_byte_i,
    input  wire logic                   broadcast_ack_i,
    input  wire logic                   slave_tx_nack_i,
    input  wire logic                   abort_event_i,
    input  wire logic                   slave_read_req_i,
    // clear register reads
    input  wire logic                   read_request_clear_reg_rd_i,
    input  wire logic                   broadcast_call_clear_reg_rd_i,
    input  wire logic                   bus_busy_clear_reg_rd_i,
    input  wire logic                   combined_interrupt_clear_reg_rd_i,
    input  wire logic                   abort_clear_reg_rd_i,
    // bus pins
    input  wire logic                   scl_i,
    output logic                        scl_o,
    output logic                        scl_oe_o,
    input  wire logic                   sda_i,
    // fifo steering and interrupt
    output logic                        tx_flush_o,
    output logic                        rx_flush_o,
    output logic                        rx_push_o,
    output logic                        rx_drop_o,
    output logic                        rx_ack_o,
    output logic                        irq_o
);

    logic [11:0] interrupt_mask;
    logic [11:0] raw_flag;
    logic [11:0] set_v;
    logic [11:0] clr_v;
    logic [11:0] masked_flag;
    logic        tx_low;
    logic        rx_high;
    logic        tx_low_q;
    logic        rx_high_q;
    logic        ien_d;
    logic        ien_fall;
    logic        rx_full_now;
    logic        clock_hold;
    logic [2:0]  scl_sync;
    logic [2:0]  sda_sync;
    logic        scl_f;
    logic        sda_f;
    logic        sda_d;
    logic        start_ev;
    logic        stop_ev;
    logic        any_clear;
    logic        hit_mask;
    logic        hit_raw;
    logic        hit_masked;

    // address decode; unmapped reads return zero, writes are dropped
    assign hit_mask   = (reg_addr_i == MASK_ADDR);
    assign hit_raw    = (reg_addr_i == RAW_STATUS_ADDR);
    assign hit_masked = (reg_addr_i == MASKED_STATUS_ADDR);

    // mask register, only the low twelve bits are stored
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            interrupt_mask <= MASK_RESET;
        end else if (cen_i && reg_wr_i && hit_mask) begin
            interrupt_mask <= reg_wdata_i[11:0];
        end
    end

    // read data is registered; upper nibble always zero
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= '0;
        end else if (cen_i && reg_rd_i) begin
            if (hit_mask) begin
                reg_rdata_o <= {4'h0, interrupt_mask};
            end else if (hit_raw) begin
                reg_rdata_o <= {4'h0, raw_flag};
            end else if (hit_masked) begin
                reg_rdata_o <= {4'h0, masked_flag};
            end else begin
                reg_rdata_o <= '0;
            end
        end
    end

    // falling edge of the internal enable ends the held error flags
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ien_d <= 1'b0;
        end else if (cen_i) begin
            ien_d <= internal_enable_signal_i;
        end
    end
    assign ien_fall = ien_d & ~internal_enable_signal_i;

    // three-flop pin synchronisers; a change counts once stages two and three agree
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
        end else if (cen_i) begin
            scl_sync <= {scl_sync[1:0], scl_i};
            sda_sync <= {sda_sync[1:0], sda_i};
        end
    end

    // filtered bus levels; idle bus reads high
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            sda_d <= 1'b1;
        end else if (cen_i) begin
            if (scl_sync[1] == scl_sync[2]) begin
                scl_f <= scl_sync[2];
            end
            if (sda_sync[1] == sda_sync[2]) begin
                sda_f <= sda_sync[2];
            end
            sda_d <= sda_f;
        end
    end

    // data edge while clock is high marks start or stop, in either role
    assign start_ev = sda_d & ~sda_f & scl_f;
    assign stop_ev  = ~sda_d & sda_f & scl_f;

    // level flags follow the fill levels each cycle while the controller is enabled
    assign tx_low  = enable_bit_i ? (tx_level_i <= tx_threshold_setting_i)
                                  : fsm_active_i;
    assign rx_high = enable_bit_i & (rx_level_i >= rx_threshold_setting_i);
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_low_q  <= 1'b0;
            rx_high_q <= 1'b0;
        end else if (cen_i) begin
            tx_low_q  <= tx_low;
            rx_high_q <= rx_high;
        end
    end

    // rx fifo full: the byte is still acked but never stored
    assign rx_full_now = (rx_level_i == FIFO_DEPTH);
    assign rx_ack_o    = rx_byte_i;
    assign rx_push_o   = rx_byte_i & ~rx_full_now & enable_bit_i;
    assign rx_drop_o   = rx_byte_i & (rx_full_now | ~enable_bit_i);

    // event sources for the sticky flags
    always_comb begin
        set_v               = '0;
        set_v[RX_UNDER_BIT] = data_command_port_rd_i & (rx_level_i == FIFO_EMPTY);
        set_v[RX_OVER_BIT]  = rx_byte_i & rx_full_now;
        set_v[TX_OVER_BIT]  = data_command_port_wr_i & (tx_level_i == FIFO_DEPTH);
        set_v[RD_REQ_BIT]   = slave_read_req_i;
        set_v[TX_ABORT_BIT] = abort_event_i;
        set_v[TX_DONE_BIT]  = slave_tx_nack_i;
        set_v[ACTIVITY_BIT] = fsm_active_i;
        set_v[STOP_BIT]     = stop_ev;
        set_v[START_BIT]    = start_ev;
        set_v[BCAST_BIT]    = broadcast_ack_i;
    end

    // clear sources; the combined clear read empties every event flag
    assign any_clear = combined_interrupt_clear_reg_rd_i;
    always_comb begin
        clr_v               = '0;
        clr_v[RX_UNDER_BIT] = ien_fall | any_clear;
        clr_v[RX_OVER_BIT]  = ien_fall | any_clear;
        clr_v[TX_OVER_BIT]  = ien_fall | any_clear;
        clr_v[RD_REQ_BIT]   = read_request_clear_reg_rd_i | any_clear;
        clr_v[TX_ABORT_BIT] = abort_clear_reg_rd_i | any_clear;
        clr_v[TX_DONE_BIT]  = any_clear;
        clr_v[ACTIVITY_BIT] = ~internal_enable_signal_i | bus_busy_clear_reg_rd_i
                              | any_clear;
        clr_v[STOP_BIT]     = any_clear;
        clr_v[START_BIT]    = any_clear;
        clr_v[BCAST_BIT]    = ~internal_enable_signal_i | broadcast_call_clear_reg_rd_i
                              | any_clear;
    end

    // one sticky cell per event bit; level bits are handled above
    genvar i;
    generate
        for (i = 0; i < FLAG_COUNT; i++) begin : g_flag
            if (i != TX_EMPTY_BIT && i != RX_FULL_BIT) begin : g_cell
                sticky_flag u_flag (
                    .sys_clk_i (sys_clk_i),
                    .rst_n_i   (rst_n_i),
                    .cen_i     (cen_i),
                    .set_i     (set_v[i]),
                    .clear_i   (clr_v[i]),
                    .flag_o    (raw_flag[i])
                );
            end else begin : g_level
                // level bits come from their own flops, so each bit has one driver
                assign raw_flag[i] = (i == TX_EMPTY_BIT) ? tx_low_q : rx_high_q;
            end
        end
    endgenerate

    // clock stretch lasts until software writes the requested byte or the internal enable goes low
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clock_hold <= 1'b0;
        end else if (cen_i) begin
            if (slave_read_req_i) begin
                clock_hold <= 1'b1;
            end else if (data_command_port_wr_i || !internal_enable_signal_i) begin
                clock_hold <= 1'b0;
            end
        end
    end
    assign scl_o    = 1'b0;
    assign scl_oe_o = clock_hold;

    // fifo flushes: disabled controller, and for the tx fifo also a pending abort
    assign tx_flush_o = ~enable_bit_i | raw_flag[TX_ABORT_BIT];
    assign rx_flush_o = ~enable_bit_i;

    // masked view and the single interrupt line
    assign masked_flag = raw_flag & interrupt_mask;
    assign irq_o       = |masked_flag;

    // ---------------- checks ----------------

    sequence seq_abort_pending;
        raw_flag[TX_ABORT_BIT] && !abort_clear_reg_rd_i && !any_clear;
    endsequence

    sequence seq_read_req_served;
        cen_i && read_request_clear_reg_rd_i && !slave_read_req_i;
    endsequence

    sequence seq_full_then_write;
        cen_i && data_command_port_wr_i && tx_level_i == FIFO_DEPTH;
    endsequence

    tx_over_set_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        seq_full_then_write |=> raw_flag[TX_OVER_BIT] && (irq_o || !interrupt_mask[TX_OVER_BIT])
    ) else $error("tx overflow not raised");

    rx_over_drop_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        rx_byte_i && rx_full_now |-> rx_ack_o && rx_drop_o && !rx_push_o
            ##1 (raw_flag[RX_OVER_BIT] || !$past(cen_i))
    ) else $error("rx overflow byte not acked and dropped");

    rx_under_set_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cen_i && data_command_port_rd_i && rx_level_i == FIFO_EMPTY |=> raw_flag[RX_UNDER_BIT]
    ) else $error("rx underflow not raised");

    err_clear_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cen_i && ien_fall && !set_v[TX_OVER_BIT] && !set_v[RX_OVER_BIT] && !set_v[RX_UNDER_BIT]
            |=> !raw_flag[TX_OVER_BIT] && !raw_flag[RX_OVER_BIT] && !raw_flag[RX_UNDER_BIT]
    ) else $error("error flags survived enable fall");

    err_hold_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cen_i && raw_flag[TX_OVER_BIT] && !ien_fall && !any_clear |=> raw_flag[TX_OVER_BIT]
    ) else $error("tx overflow lost while held");

    rx_full_off_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cen_i && !enable_bit_i |-> rx_flush_o ##1 !raw_flag[RX_FULL_BIT]
    ) else $error("rx level flag not cleared on disable");

    tx_low_track_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cen_i && enable_bit_i |=> raw_flag[TX_EMPTY_BIT] ==
            ($past(tx_level_i) <= $past(tx_threshold_setting_i))
    ) else $error("tx level flag wrong");

    tx_low_off_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cen_i && !enable_bit_i |-> tx_flush_o
            ##1 raw_flag[TX_EMPTY_BIT] == $past(fsm_active_i)
    ) else $error("tx level flag wrong while disabled");

    rx_high_track_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cen_i && enable_bit_i && rx_level_i >= rx_threshold_setting_i |=> raw_flag[RX_FULL_BIT]
    ) else $error("rx level flag missing");

    rd_req_clear_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        seq_read_req_served |=> !raw_flag[RD_REQ_BIT]
    ) else $error("read request not cleared");

    clock_hold_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cen_i && slave_read_req_i |=> raw_flag[RD_REQ_BIT] && scl_oe_o && !scl_o
    ) else $error("clock not held low on read request");

    abort_flush_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        seq_abort_pending |-> tx_flush_o ##1 (raw_flag[TX_ABORT_BIT] || !$past(cen_i))
    ) else $error("tx fifo released while abort pending");

    activity_sticky_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cen_i && raw_flag[ACTIVITY_BIT] && internal_enable_signal_i
            && !bus_busy_clear_reg_rd_i && !any_clear |=> raw_flag[ACTIVITY_BIT]
    ) else $error("activity flag dropped");

    bcast_set_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cen_i && broadcast_ack_i |=> raw_flag[BCAST_BIT]
    ) else $error("broadcast call flag missing");

    start_seen_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cen_i && start_ev |=> raw_flag[START_BIT]
    ) else $error("start not recorded");

    stop_seen_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cen_i && stop_ev |=> raw_flag[STOP_BIT]
    ) else $error("stop not recorded");

    tx_done_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cen_i && slave_tx_nack_i |=> raw_flag[TX_DONE_BIT]
    ) else $error("transmit done not raised");

    reserved_zero_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        reg_rdata_o[15:12] == 4'h0
    ) else $error("reserved bits not zero");

    mask_gate_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        irq_o == |(raw_flag & interrupt_mask) && (masked_flag & ~interrupt_mask) == 12'h000
    ) else $error("interrupt does not follow masked status");

    mask_reset_a: assert property (
        @(posedge sys_clk_i) $rose(rst_n_i) |-> interrupt_mask == MASK_RESET
    ) else $error("mask reset value wrong");

endmodule : irq_status_mask

// ### pkg/irq_stat_pkg.sv
// Function
// - tx level-low flag is 1 while tx fill level is at or below tx threshold
// - controller off: flush tx fifo; tx level-low follows state machine activity
// - tx overflow sets on a command write while tx fifo holds 32
// - over/underflow flags hold while disabled, clear when internal enable falls
// - rx level-high flag is 1 while rx fill level reaches rx threshold
// - controller off: flush rx fifo at once; rx level-high clears on the next clock
// - byte arriving into full rx fifo is acked, dropped, sets rx overflow
// - rx underflow sets on a command read while rx fifo is empty
// - read-request flag clears right after its clear register is read
// - mask bits 11..0 gate masked status; reset value 0x8FF
// - broadcast-call flag sets on acked call; clears on disable or clear read
// - start-seen flag sets on any start or repeated start on the bus
// - stop-seen flag sets on any stop on the bus
// - activity flag sticky; clears on disable, two clear reads, or reset
// - slave transmitter sets transmit-done when master withholds ack
// - tx fifo stays flushed while abort flag set, until abort clear read
// - slave read request sets flag and holds clock low until serviced
package irq_stat_pkg;

    // register byte addresses
    localparam logic [31:0] MASKED_STATUS_ADDR = 32'h5000_132C;
    localparam logic [31:0] MASK_ADDR          = 32'h5000_1330;
    localparam logic [31:0] RAW_STATUS_ADDR    = 32'h5000_1334;

    // status / mask bit positions
    localparam int RX_UNDER_BIT  = 0;
    localparam int RX_OVER_BIT   = 1;
    localparam int RX_FULL_BIT   = 2;
    localparam int TX_OVER_BIT   = 3;
    localparam int TX_EMPTY_BIT  = 4;
    localparam int RD_REQ_BIT    = 5;
    localparam int TX_ABORT_BIT  = 6;
    localparam int TX_DONE_BIT   = 7;
    localparam int ACTIVITY_BIT  = 8;
    localparam int STOP_BIT      = 9;
    localparam int START_BIT     = 10;
    localparam int BCAST_BIT     = 11;

    localparam int FLAG_COUNT    = 12;
    localparam int REG_WIDTH     = 16;
    localparam int LEVEL_WIDTH   = 6;

    // reset values
    localparam logic [11:0] MASK_RESET   = 12'h8FF;
    localparam logic [11:0] RAW_RESET    = 12'h000;

    // fifo depth, both directions
    localparam logic [5:0]  FIFO_DEPTH   = 6'h20;
    localparam logic [5:0]  FIFO_EMPTY   = 6'h00;

endpackage : irq_stat_pkg

// ### rtl/sticky_flag.sv
`timescale 1ns/1ps
// one status flag: set wins over clear so no event is lost
module sticky_flag (
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    input  wire logic cen_i,
    input  wire logic set_i,
    input  wire logic clear_i,
    output logic      flag_o
);

    // hold, set or clear only while the clock enable is high
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_o <= 1'b0;
        end else if (cen_i) begin
            if (set_i) begin
                flag_o <= 1'b1;
            end else if (clear_i) begin
                flag_o <= 1'b0;
            end
        end
    end

endmodule : sticky_flag

// ### tb/bus_partner.sv
`timescale 1ns/1ps
// far-side bus master: makes start and stop conditions on the two wires
module bus_partner (
    input  wire logic sys_clk_i,
    input  wire logic scl_drive_i,
    input  wire logic scl_oe_i,
    output logic      scl_line_o,
    output logic      sda_line_o
);
    logic scl_drv = 1'b1;  // 1 = released, pull-up wins
    logic sda_drv = 1'b1;

    // open-drain wire: whoever pulls low wins
    assign scl_line_o = scl_drv & ~(scl_oe_i & ~scl_drive_i);
    assign sda_line_o = sda_drv;

    // each level held 8 cycles so the input filter surely sees it
    task automatic hold_lvl(input logic s, input logic d);
        @(negedge sys_clk_i);
        scl_drv = s;
        sda_drv = d;
        repeat (8) @(negedge sys_clk_i);
    endtask : hold_lvl

    // data falls while clock is high
    task automatic start_cond();
        hold_lvl(1'b1, 1'b1);
        hold_lvl(1'b1, 1'b0);
        hold_lvl(1'b0, 1'b0);
    endtask : start_cond

    // a stretched clock is waited out before data may rise
    task automatic stop_cond();
        hold_lvl(1'b0, 1'b0);
        scl_drv = 1'b1;
        wait (scl_line_o);
        hold_lvl(1'b1, 1'b0);
        hold_lvl(1'b1, 1'b1);
    endtask : stop_cond
endmodule : bus_partner

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
    import irq_stat_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic [31:0] addr    = 32'h0;
    logic        wr = 1'b0, rd = 1'b0, en = 1'b0, ien = 1'b0, act = 1'b0, cen = 1'b1;
    logic [15:0] wdata   = 16'h0, rdata, r;
    logic [5:0]  txl = 6'h00, rxl = 6'h00, txt = 6'h00, rxt = 6'h00;
    logic [11:0] ev      = 12'h000;  // event and clear-read strobes
    logic [11:0] mask_sh = 12'h8FF;  // expected mask contents
    logic        scl_line, sda_line, scl_o, scl_oe, txf, rxf, push, drop, ack, irq;
    integer      seed = 23, miscompares = 0, check_count = 0, cycles = 0;

    always #5 sys_clk = ~sys_clk;

    irq_status_mask dut_u (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .cen_i(cen),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .enable_bit_i(en), .internal_enable_signal_i(ien),
        .fsm_active_i(act), .tx_level_i(txl), .rx_level_i(rxl),
        .tx_threshold_setting_i(txt), .rx_threshold_setting_i(rxt),
        .data_command_port_wr_i(ev[0]), .data_command_port_rd_i(ev[1]),
        .rx_byte_i(ev[2]), .broadcast_ack_i(ev[3]), .slave_tx_nack_i(ev[4]),
        .abort_event_i(ev[5]), .slave_read_req_i(ev[6]),
        .read_request_clear_reg_rd_i(ev[7]), .broadcast_call_clear_reg_rd_i(ev[8]),
        .bus_busy_clear_reg_rd_i(ev[9]), .combined_interrupt_clear_reg_rd_i(ev[10]),
        .abort_clear_reg_rd_i(ev[11]), .scl_i(scl_line), .scl_o(scl_o),
        .scl_oe_o(scl_oe), .sda_i(sda_line), .tx_flush_o(txf), .rx_flush_o(rxf),
        .rx_push_o(push), .rx_drop_o(drop), .rx_ack_o(ack), .irq_o(irq));

    bus_partner partner_u (.sys_clk_i(sys_clk), .scl_drive_i(scl_o), .scl_oe_i(scl_oe),
        .scl_line_o(scl_line), .sda_line_o(sda_line));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    // a hung wait would otherwise stall the run forever
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    // strobes last one cycle, driven from falling edges
    task automatic rd_reg(input logic [31:0] a, output logic [15:0] d);
        @(negedge sys_clk);
        addr = a;
        rd   = 1'b1;
        @(negedge sys_clk);
        rd   = 1'b0;
        d    = rdata;
    endtask : rd_reg

    task automatic wr_reg(input logic [31:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        addr  = a;
        wdata = d;
        wr    = 1'b1;
        @(negedge sys_clk);
        wr    = 1'b0;
    endtask : wr_reg

    task automatic pulse(input int b);
        @(negedge sys_clk);
        ev[b] = 1'b1;
        @(negedge sys_clk);
        ev[b] = 1'b0;
    endtask : pulse

    // raw bits under care, then masked view and interrupt line
    task automatic chk_raw(input logic [15:0] exp, input logic [15:0] care);
        logic [15:0] m;
        rd_reg(RAW_STATUS_ADDR, r);
        cmp(r & care, exp & care);
        rd_reg(MASKED_STATUS_ADDR, m);
        cmp(m, r & {4'h0, mask_sh});
        cmp({15'h0, irq}, {15'h0, |m});
    endtask : chk_raw

    function automatic logic [15:0] lvl_exp(input logic [5:0] tl, tt, rl, rt);
        return {11'h0, tl <= tt, 1'b0, rl >= rt, 2'b00};
    endfunction : lvl_exp

    task automatic settle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : settle

    initial begin
        settle(6);
        rst_n = 1'b1;
        rd_reg(MASK_ADDR, r);
        cmp(r, 16'h08FF);
        chk_raw(16'h0000, 16'hFFFF);
        rd_reg(32'h5000_1300, r);
        cmp(r, 16'h0000);
        wr_reg(MASK_ADDR, 16'hFFFF);
        mask_sh = 12'hFFF;
        rd_reg(MASK_ADDR, r);
        cmp(r, 16'h0FFF);
        wr_reg(RAW_STATUS_ADDR, 16'hFFFF);
        chk_raw(16'h0000, 16'hFFFF);
        $display("test reset done");
        en  = 1'b1;
        ien = 1'b1;
        // random levels and masks; every fourth pass sits on the threshold
        for (int i = 0; i < 16; i++) begin
            txt = 6'({$random(seed)} % 33);
            rxt = 6'({$random(seed)} % 33);
            txl = (i % 4 == 0) ? txt : 6'({$random(seed)} % 33);
            rxl = (i % 4 == 0) ? rxt : 6'({$random(seed)} % 33);
            wr_reg(MASK_ADDR, 16'($random(seed)));
            mask_sh = wdata[11:0];
            rd_reg(MASK_ADDR, r);
            cmp(r, {4'h0, mask_sh});
            chk_raw(lvl_exp(txl, txt, rxl, rxt), 16'h0014);
        end
        wr_reg(MASK_ADDR, 16'h0FFF);
        mask_sh = 12'hFFF;
        $display("test levels done");
        rxl = 6'h20;
        rxt = 6'h01;
        txl = 6'h20;
        txt = 6'h00;
        en  = 1'b0;
        act = 1'b1;
        settle(2);
        cmp({14'h0, txf, rxf}, 16'h0003);
        chk_raw(16'h0010, 16'h0014);
        act = 1'b0;
        settle(2);
        chk_raw(16'h0000, 16'h0014);
        en  = 1'b1;
        $display("test disable done");
        txl = 6'h1F;
        pulse(0);
        chk_raw(16'h0000, 16'h0008);
        txl = 6'h20;
        pulse(0);
        chk_raw(16'h0008, 16'h0008);
        rxl = 6'h00;
        pulse(1);
        chk_raw(16'h0001, 16'h0001);
        rxl = 6'h1F;
        @(negedge sys_clk);
        ev[2] = 1'b1;
        #1 cmp({13'h0, ack, drop, push}, 16'h0005);
        @(negedge sys_clk);
        ev[2] = 1'b0;
        rxl = 6'h20;
        @(negedge sys_clk);
        ev[2] = 1'b1;
        #1 cmp({13'h0, ack, drop, push}, 16'h0006);
        @(negedge sys_clk);
        ev[2] = 1'b0;
        chk_raw(16'h000B, 16'h000B);
        en  = 1'b0;
        act = 1'b1;
        settle(3);
        chk_raw(16'h000B, 16'h000B);
        ien = 1'b0;
        act = 1'b0;
        settle(3);
        chk_raw(16'h0000, 16'h010B);
        en  = 1'b1;
        ien = 1'b1;
        $display("test overflow done");
        txl = 6'h00;
        pulse(3);
        pulse(4);
        pulse(5);
        cmp({15'h0, txf}, 16'h0001);
        chk_raw(16'h08C0, 16'h08C0);
        pulse(8);
        pulse(11);
        cmp({15'h0, txf}, 16'h0000);
        chk_raw(16'h0080, 16'h08C0);
        pulse(6);
        cmp({14'h0, scl_oe, scl_line}, 16'h0002);
        pulse(0);
        cmp({14'h0, scl_oe, scl_line}, 16'h0001);
        chk_raw(16'h0020, 16'h0020);
        pulse(7);
        chk_raw(16'h0000, 16'h0020);
        // a frozen clock enable must not take the event
        cen = 1'b0;
        pulse(3);
        cen = 1'b1;
        chk_raw(16'h0000, 16'h0800);
        $display("test slave done");
        act = 1'b1;
        settle(1);
        act = 1'b0;
        chk_raw(16'h0100, 16'h0100);
        pulse(9);
        chk_raw(16'h0000, 16'h0100);
        partner_u.start_cond();
        chk_raw(16'h0400, 16'h0600);
        partner_u.stop_cond();
        chk_raw(16'h0600, 16'h0600);
        act = 1'b1;
        settle(1);
        act = 1'b0;
        pulse(10);
        chk_raw(16'h0000, 16'h0780);
        $display("test bus done");
        complete_run();
    end
endmodule : tb
